// [sensor_hub.sv]
// Contract
// - four ports merge onto one lane-configurable output
// - each sensor gets own virtual channel id
// - output carries sync short and data packets
// - csi2 input uses 40-bit link units
// - raw input uses 28-bit slower link units
// - recover forward stream, drive reverse control
// - control channel continuous, never waits blanking
// - per-port format in setup bits 1:0
// - mode strap can select the format
// - output is always csi2 packets
// - any port may forward to output
// - csi2 ports remap incoming virtual channels
// - csi2 link accepts up to 4.16 Gbps
// - synchronous rates derive from reference clock
// - non-synchronous back channel at 10 Mbps
// - output rate independent of link rate
// - back channel default 50M (2.5M on raw ports), 010 gives 10M
`timescale 1ns/1ps
`include "hub_defs.svh"

module sensor_hub import hub_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// link pins
	input  wire logic        link_clk,
	input  wire logic [3:0]  fwd_data,
	output logic [3:0]       back_line,
	input  wire logic        mode_strap,
	// csi2 transmit word stream towards the phy
	output csi_word_t        tx_word,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [1:0]       tx_lanes_m1
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
		hdr_ecc = {2'b00, ^(d & `ECC_M5), ^(d & `ECC_M4), ^(d & `ECC_M3),
		           ^(d & `ECC_M2), ^(d & `ECC_M1), ^(d & `ECC_M0)};
	endfunction

	function automatic logic [3:0] fold4(input logic [35:0] d);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 9; i++)
			r = r ^ d[i*4 +: 4];
		fold4 = r;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic       lclk_d_q;
	logic       strap_s2;
	logic       link_edge;
	logic [3:0] fwd_s2;

	always_ff @(posedge aclk) begin
		pin_s1_q <= {mode_strap, link_clk};
		pin_s2_q <= pin_s1_q;
		lclk_d_q <= pin_s2_q[0];
	end

	assign strap_s2  = pin_s2_q[1];
	assign link_edge = pin_s2_q[0] && !lclk_d_q;

	logic [3:0] data_s1_q;
	logic [3:0] data_s2_q;

	always_ff @(posedge aclk) begin
		data_s1_q <= fwd_data;
		data_s2_q <= data_s1_q;
	end

	assign fwd_s2 = data_s2_q;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [3:0] fwd_en_q;
	logic [1:0] lanes_q;
	logic [1:0] port_sel_q;
	logic       strap_done_q;
	rx_format_t fmt_q [4];
	logic [2:0] rate_q [4];
	logic [7:0] vc_map_q [4];
	logic [7:0] fwd_byte_q [4];
	logic [3:0] fresh_q;
	logic [3:0] lock_q;
	logic [3:0] ovf_q;
	logic [3:0] bc_busy;
	logic [3:0] bc_start;
	logic [7:0] bc_byte_q;
	logic [3:0] raw_mode;

	assign tx_lanes_m1 = lanes_q;

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	logic        aw_held_q;
	logic        w_held_q;
	logic [31:0] awaddr_q;
	logic [32:0] wdata_q;
	logic        wr_fire;
	logic [7:0]  wr_idx;
	logic        wr_map;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_idx        = awaddr_q[9:2];
	assign wr_map        = (awaddr_q[31:10] == 22'h0) && (
	                       wr_idx == `IDX_FWD_CTL || wr_idx == `IDX_PORT_SEL ||
	                       wr_idx == `IDX_BC_RATE || wr_idx == `IDX_RX_PORT_SETUP ||
	                       wr_idx == `IDX_VC_MAP || wr_idx == `IDX_BC_TX ||
	                       wr_idx == `IDX_RX_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= 32'h0;
			wdata_q      <= 33'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= {s_axi_wstrb[0], s_axi_wdata};
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// only the low byte lane holds writable register bits
	logic       wr_lo;
	logic [3:0] sel_hot;

	assign wr_lo   = wr_fire && wdata_q[32];
	assign sel_hot = 4'h1 << port_sel_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fwd_en_q     <= `FWD_EN_RST;
			lanes_q      <= `LANES_RST;
			port_sel_q   <= 2'h0;
			strap_done_q <= 1'b0;
			bc_byte_q    <= 8'h00;
			for (int p = 0; p < 4; p++) begin
				fmt_q[p]    <= FMT_CSI2;
				rate_q[p]   <= `BC_RATE_RST;
				vc_map_q[p] <= `VC_MAP_RST;
			end
		end else begin
			if (!strap_done_q) begin
				strap_done_q <= 1'b1;
				for (int p = 0; p < 4; p++)
					fmt_q[p] <= strap_s2 ? FMT_RAW12HF : FMT_CSI2;
			end
			if (wr_lo && wr_idx == `IDX_FWD_CTL) begin
				fwd_en_q <= wdata_q[3:0];
				lanes_q  <= wdata_q[5:4];
			end else if (wr_lo && wr_idx == `IDX_PORT_SEL)
				port_sel_q <= wdata_q[1:0];
			else if (wr_lo && wr_idx == `IDX_BC_RATE)
				rate_q[port_sel_q] <= wdata_q[2:0];
			else if (wr_lo && wr_idx == `IDX_RX_PORT_SETUP)
				fmt_q[port_sel_q] <= rx_format_t'(wdata_q[`FMT_LSB +: 2]);
			else if (wr_lo && wr_idx == `IDX_VC_MAP)
				vc_map_q[port_sel_q] <= wdata_q[7:0];
			else if (wr_lo && wr_idx == `IDX_BC_TX)
				bc_byte_q <= wdata_q[7:0];
		end
	end

	// a write to the back-channel byte launches it on the chosen port
	assign bc_start = (wr_lo && wr_idx == `IDX_BC_TX) ? sel_hot : 4'h0;

	// ------------------------------------------------------------
	// axi4-lite read path; reading status clears the fresh flag
	// ------------------------------------------------------------
	logic [7:0]  rd_idx;
	logic [31:0] rd_val;
	logic        rd_map;
	logic        rd_fire;
	logic [3:0]  fresh_clr;

	assign rd_idx  = s_axi_araddr[9:2];
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_map  = (s_axi_araddr[31:10] == 22'h0);
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_val =
		!rd_map ? 32'h0 :
		(rd_idx == `IDX_FWD_CTL) ? {26'h0, lanes_q, fwd_en_q} :
		(rd_idx == `IDX_PORT_SEL) ? {30'h0, port_sel_q} :
		(rd_idx == `IDX_BC_RATE) ? {29'h0, rate_q[port_sel_q]} :
		(rd_idx == `IDX_RX_PORT_SETUP) ? {30'h0, fmt_q[port_sel_q]} :
		(rd_idx == `IDX_VC_MAP) ? {24'h0, vc_map_q[port_sel_q]} :
		(rd_idx == `IDX_BC_TX) ? {24'h0, bc_byte_q} :
		(rd_idx == `IDX_RX_STATUS) ? {20'h0, ovf_q[port_sel_q], bc_busy[port_sel_q],
		                              lock_q[port_sel_q], fresh_q[port_sel_q],
		                              fwd_byte_q[port_sel_q]} : 32'h0;
	assign fresh_clr = (rd_fire && rd_map && rd_idx == `IDX_RX_STATUS) ? sel_hot : 4'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= (rd_val == 32'h0 && !(rd_map && (rd_idx == `IDX_FWD_CTL ||
			                rd_idx == `IDX_PORT_SEL || rd_idx == `IDX_BC_RATE ||
			                rd_idx == `IDX_RX_PORT_SETUP || rd_idx == `IDX_VC_MAP ||
			                rd_idx == `IDX_BC_TX || rd_idx == `IDX_RX_STATUS))) ? 2'h2 : 2'h0;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// forward link deframers, one per port
	// ------------------------------------------------------------
	logic [39:0] sh_q [4];
	logic [5:0]  bit_cnt_q [4];
	logic [3:0]  fv_q;
	logic [3:0]  pend_q;
	csi_word_t   word_q [4];
	logic [3:0]  grant;

	generate
		for (genvar p = 0; p < 4; p++) begin : g_port
			logic [5:0]  flen;
			logic [39:0] nsh;
			logic        unit_end;
			logic        mark_ok;
			logic        chk_ok;
			logic [7:0]  i2c_byte;
			logic [23:0] hdr_in;
			logic [23:0] hdr_out;
			logic [1:0]  vc_new;
			logic        raw_fv;
			logic        raw_lv;
			logic        emit;
			csi_word_t   nword;

			assign raw_mode[p] = (fmt_q[p] != FMT_CSI2);
			assign flen = raw_mode[p] ? `FRAME_LEN_RAW : `FRAME_LEN_CSI2;
			assign nsh  = {sh_q[p][38:0], fwd_s2[p]};
			assign unit_end = link_edge && (bit_cnt_q[p] == flen - 6'd1);
			assign mark_ok  = raw_mode[p] ? (nsh[27:26] == `FRAME_MARKER)
			                              : (nsh[39:38] == `FRAME_MARKER);
			assign chk_ok   = raw_mode[p] ? (fold4({14'h0, nsh[27:6]}) == nsh[3:0])
			                              : (fold4(nsh[39:4]) == nsh[3:0]);
			assign i2c_byte = raw_mode[p] ? nsh[11:4] : nsh[37:30];
			assign raw_fv   = nsh[25];
			assign raw_lv   = nsh[24];

			// incoming vc is rewritten through the port's map, then ecc redone
			assign hdr_in  = nsh[27:4];
			assign vc_new  = vc_map_q[p][hdr_in[7:6]*2 +: 2];
			assign hdr_out = {hdr_in[23:8], vc_new, hdr_in[5:0]};

			always_comb begin
				emit  = 1'b0;
				nword = '0;
				if (!raw_mode[p]) begin
					emit = nsh[28];
					if (nsh[29])
						nword = '{1'b1, {hdr_ecc(hdr_out), hdr_out}};
					else
						nword = '{1'b0, {8'h00, hdr_in}};
				end else if (raw_fv != fv_q[p]) begin
					emit  = 1'b1;
					nword = '{1'b1, {hdr_ecc({16'h0, vc_map_q[p][1:0],
					          raw_fv ? `DT_FRAME_START : `DT_FRAME_END}),
					          16'h0, vc_map_q[p][1:0],
					          raw_fv ? `DT_FRAME_START : `DT_FRAME_END}};
				end else if (raw_lv) begin
					emit  = 1'b1;
					nword = '{1'b0, {20'h0, nsh[23:12]}};
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sh_q[p]       <= 40'h0;
					bit_cnt_q[p]  <= 6'h0;
					lock_q[p]     <= 1'b0;
					fv_q[p]       <= 1'b0;
					pend_q[p]     <= 1'b0;
					word_q[p]     <= '0;
					ovf_q[p]      <= 1'b0;
					fwd_byte_q[p] <= 8'h00;
					fresh_q[p]    <= 1'b0;
				end else begin
					if (link_edge) begin
						sh_q[p] <= nsh;
						bit_cnt_q[p] <= unit_end ? 6'h0 : bit_cnt_q[p] + 6'h1;
					end
					// a failed marker drops lock; the bit count restarts at zero as after a good unit
					if (unit_end && !mark_ok) begin
						lock_q[p]    <= 1'b0;
						bit_cnt_q[p] <= 6'h0;
					end else if (unit_end)
						lock_q[p] <= chk_ok;
					if (grant[p])
						pend_q[p] <= 1'b0;
					if (unit_end && mark_ok && chk_ok) begin
						fwd_byte_q[p] <= i2c_byte;
						if (raw_mode[p])
							fv_q[p] <= raw_fv;
						if (emit && fwd_en_q[p]) begin
							if (pend_q[p] && !grant[p])
								ovf_q[p] <= 1'b1;
							else begin
								pend_q[p] <= 1'b1;
								word_q[p] <= nword;
							end
						end
					end
					if (unit_end && mark_ok && chk_ok)
						fresh_q[p] <= 1'b1;
					else if (fresh_clr[p])
						fresh_q[p] <= 1'b0;
				end
			end

			back_link_tx u_bc (
				.aclk                  (aclk),
				.aresetn               (aresetn),
				.back_link_rate_select (rate_q[p]),
				.raw_mode              (raw_mode[p]),
				.tx_byte               (wdata_q[7:0]),
				.tx_start              (bc_start[p]),
				.busy                  (bc_busy[p]),
				.line                  (back_line[p])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// round-robin merge; the phy's ready paces the output so the
	// link rate never sets the transmit rate
	// ------------------------------------------------------------
	logic [1:0] rr_q;
	logic       out_free;
	logic [1:0] pick;
	logic       pick_ok;

	assign out_free = !tx_valid || tx_ready;
	assign pick_ok  = |pend_q;
	assign pick =
		pend_q[2'(rr_q + 2'd1)] ? 2'(rr_q + 2'd1) :
		pend_q[2'(rr_q + 2'd2)] ? 2'(rr_q + 2'd2) :
		pend_q[2'(rr_q + 2'd3)] ? 2'(rr_q + 2'd3) : rr_q;
	assign grant = (out_free && pick_ok) ? (4'h1 << pick) : 4'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rr_q     <= 2'h3;
			tx_valid <= 1'b0;
			tx_word  <= '0;
		end else if (out_free) begin
			tx_valid <= pick_ok;
			if (pick_ok) begin
				tx_word <= word_q[pick];
				rr_q    <= pick;
			end
		end
	end

endmodule // sensor_hub

// [hub_defs.svh]
`ifndef HUB_DEFS_SVH
`define HUB_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FWD_CTL       8'h20
`define IDX_PORT_SEL      8'h4C
`define IDX_BC_RATE       8'h58
`define IDX_RX_PORT_SETUP 8'h6D
`define IDX_VC_MAP        8'h70
`define IDX_BC_TX         8'h71
`define IDX_RX_STATUS     8'h72

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FMT_LSB           0
`define FWD_EN_RST        4'hF
`define LANES_RST         2'h3
`define VC_MAP_RST        8'hE4
`define BC_RATE_RST       3'h0
`define BC_RATE_NONSYNC   3'h2
`define STAT_FRESH_BIT    8
`define STAT_LOCK_BIT     9
`define STAT_BUSY_BIT     10
`define STAT_OVF_BIT      11

// ----------------------------------------------------------------
// link framing
// ----------------------------------------------------------------
`define FRAME_LEN_CSI2    6'd40
`define FRAME_LEN_RAW     6'd28
`define FRAME_MARKER      2'h2
`define DT_FRAME_START    6'h00
`define DT_FRAME_END      6'h01
`define LANE_MAX_MBPS     1600
`define FWD_MAX_MBPS      4160

// ----------------------------------------------------------------
// clocking; rates in kbit/s
// ----------------------------------------------------------------
`define ACLK_KHZ          50000
`define REF_KHZ           25000
`define FWD_REF_MULT      160
`define PCLK_REF_MULT     4
`define BC_REF_MULT       2
`define BC_SYNC_KBPS      (`REF_KHZ * `BC_REF_MULT)
`define BC_NONSYNC_KBPS   10000
`define BC_RAW_KBPS       2500
`define BC_DIV_SYNC       (`ACLK_KHZ / `BC_SYNC_KBPS)
`define BC_DIV_NONSYNC    (`ACLK_KHZ / `BC_NONSYNC_KBPS)
`define BC_DIV_RAW        (`ACLK_KHZ / `BC_RAW_KBPS)

// ----------------------------------------------------------------
// header ecc parity masks over the 24 header bits
// ----------------------------------------------------------------
`define ECC_M0            24'hF12CB7
`define ECC_M1            24'hF2555B
`define ECC_M2            24'h749A6D
`define ECC_M3            24'hB8E38E
`define ECC_M4            24'hDF03F0
`define ECC_M5            24'hEFFC00

`endif

// [hub_pkg.sv]
package hub_pkg;

	typedef enum logic [1:0] {
		FMT_CSI2    = 2'b00,
		FMT_RAW12HF = 2'b01,
		FMT_RAW12LF = 2'b10,
		FMT_RAW10   = 2'b11
	} rx_format_t;

	typedef enum logic [1:0] {
		BC_IDLE  = 2'b00,
		BC_SHIFT = 2'b01
	} bc_state_t;

	typedef struct packed {
		logic        hdr;
		logic [31:0] data;
	} csi_word_t;

endpackage

// [back_link_tx.sv]
`timescale 1ns/1ps
`include "hub_defs.svh"

module back_link_tx import hub_pkg::*; (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [2:0] back_link_rate_select,
	input  wire logic       raw_mode,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_start,
	output logic            busy,
	output logic            line
);

	// ------------------------------------------------------------
	// bit-rate enable
	// ------------------------------------------------------------
	logic [4:0] div_q;
	logic [4:0] div_last;
	logic       bit_en;

	assign div_last = (back_link_rate_select == `BC_RATE_NONSYNC) ? 5'(`BC_DIV_NONSYNC - 1) :
	                  (back_link_rate_select == `BC_RATE_RST && raw_mode) ? 5'(`BC_DIV_RAW - 1) :
	                  5'(`BC_DIV_SYNC - 1);
	assign bit_en   = (div_q >= div_last);

	always_ff @(posedge aclk) begin
		if (!aresetn || bit_en)
			div_q <= 5'h00;
		else
			div_q <= div_q + 5'h01;
	end

	// ------------------------------------------------------------
	// serialiser: idle line is high and keeps toggling nothing, so
	// a byte leaves at the next bit slot without waiting for video
	// ------------------------------------------------------------
	bc_state_t  state_q;
	logic [9:0] sh_q;
	logic [3:0] cnt_q;

	assign busy = (state_q != BC_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= BC_IDLE;
			sh_q    <= 10'h3FF;
			cnt_q   <= 4'h0;
			line    <= 1'b1;
		end else begin
			case (state_q)
				BC_IDLE: begin
					if (tx_start) begin
						sh_q    <= {1'b1, tx_byte, 1'b0};
						cnt_q   <= 4'h0;
						state_q <= BC_SHIFT;
					end
				end
				BC_SHIFT: begin
					if (bit_en) begin
						line  <= sh_q[0];
						sh_q  <= {1'b1, sh_q[9:1]};
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h9)
							state_q <= BC_IDLE;
					end
				end
				default: state_q <= BC_IDLE;
			endcase
		end
	end

endmodule // back_link_tx

// [hub_checker.sv]
`timescale 1ns/1ps
`include "hub_defs.svh"

module hub_checker import hub_pkg::*; (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [3:0] back_line,
	input wire csi_word_t  tx_word,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [1:0] tx_lanes_m1
);
	// ----------------
	// header ecc rebuilt apart from the design
	// ----------------
	logic [23:0] it_w;
	logic [5:0]  ecc_w;
	assign it_w = tx_word.data[23:0];
	assign ecc_w = {^(it_w & `ECC_M5), ^(it_w & `ECC_M4), ^(it_w & `ECC_M3),
		^(it_w & `ECC_M2), ^(it_w & `ECC_M1), ^(it_w & `ECC_M0)};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ecc;
		tx_valid && tx_word.hdr |-> tx_word.data[31:24] == {2'b00, ecc_w};
	endproperty
	a_ecc: assert property (p_ecc) else $error("header ecc wrong");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped");
	property p_pay;
		tx_valid && !tx_word.hdr |-> tx_word.data[31:24] == 8'h00;
	endproperty
	a_pay: assert property (p_pay) else $error("payload top byte set");
	property p_lanes;
		$rose(aresetn) |-> tx_lanes_m1 == 2'h3;
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane reset wrong");
	property p_back_idle;
		$rose(aresetn) |-> back_line == 4'hF;
	endproperty
	a_back_idle: assert property (p_back_idle) else $error("back idle low");
	property p_bc_stop;
		$fell(back_line[0]) |-> ##[1:200] back_line[0];
	endproperty
	a_bc_stop: assert property (p_bc_stop) else $error("back line stuck");
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write resp");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("no read data");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("extra write resp");

	c_hdr: cover property (tx_valid && tx_ready && tx_word.hdr);
	c_bc: cover property ($fell(back_line[0]));
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // hub_checker

// [hub_partner.sv]
`timescale 1ns/1ps

module hub_partner import hub_pkg::*; (
	input  wire logic       aclk,
	input  wire logic       slow,
	output logic            link_clk,
	output logic [3:0]      fwd_data,
	output logic            tx_ready
);
	logic [7:0] lfsr_q;
	initial begin
		link_clk = 1'b0;
		fwd_data = 4'h0;
		tx_ready = 1'b0;
		lfsr_q = 8'h5A;
	end
	// ----------------
	// sink: stalls on a shifting pattern when slow
	// ----------------
	always @(posedge aclk) begin
		lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
		tx_ready <= !slow || lfsr_q[0];
	end
	// ----------------
	// serializer: clock stands still between units
	// ----------------
	task automatic send(input int port, input logic [39:0] unit, input int len);
		#7;
		for (int i = len - 1; i >= 0; i--) begin
			fwd_data[port] = unit[i];
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
		// released lines show the inverse, never a stale copy
		fwd_data = ~fwd_data;
	endtask
endmodule // hub_partner

// [sensor_hub_test.sv]
`timescale 1ns/1ps
`include "hub_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module sensor_hub_test import hub_pkg::*; ;
	logic        aclk, aresetn, mode_strap, slow, link_clk, tx_valid, tx_ready;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, seed, r;
	logic [1:0]  bresp, rresp, lanes, eb2, exp_b[$];
	logic [1:0]  fmt [4];
	logic [3:0]  fwd_data, back_line;
	logic [23:0] it, mit;
	logic [33:0] er, exp_r[$];
	logic [8:0]  bc_got, ebc, exp_bc[$];
	csi_word_t   tx_word, et, exp_tx[$];
	int          fail_count, comparisons, cyc, bc_port, bc_per;

	sensor_hub sensor_hub_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link_clk(link_clk), .fwd_data(fwd_data),
		.back_line(back_line), .mode_strap(mode_strap), .tx_word(tx_word),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_lanes_m1(lanes));
	hub_partner hub_partner_inst (.aclk(aclk), .slow(slow), .link_clk(link_clk),
		.fwd_data(fwd_data), .tx_ready(tx_ready));

	always #10 aclk = ~aclk;

	// ----------------
	// helpers
	// ----------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] ecc(input logic [23:0] h);
		return {2'b00, ^(h & `ECC_M5), ^(h & `ECC_M4), ^(h & `ECC_M3),
			^(h & `ECC_M2), ^(h & `ECC_M1), ^(h & `ECC_M0)};
	endfunction
	function automatic logic [39:0] csi_unit(input logic [7:0] b, input logic h,
		input logic [23:0] x);
		logic [39:0] u;
		u = {2'b10, b, h, 1'b1, x, 4'h0};
		for (int i = 1; i < 10; i++) u[3:0] ^= u[4*i +: 4];
		return u;
	endfunction
	function automatic logic [39:0] raw_unit(input logic [1:0] fl, input logic [11:0] px);
		logic [39:0] u;
		logic [35:0] t;
		u = {12'h0, 2'b10, fl, px, 8'hC3, 4'h0};
		t = {14'h0, u[27:6]};
		for (int i = 0; i < 9; i++) u[3:0] ^= t[4*i +: 4];
		return u;
	endfunction
	task automatic do_reset(input logic strap);
		@(posedge aclk);
		aresetn <= 1'b0;
		mode_strap <= strap;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge aclk);
		exp_b.push_back(rsp);
		awaddr <= {22'h0, idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [33:0] e);
		@(posedge aclk);
		exp_r.push_back(e);
		araddr <= {22'h0, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic bc(input int port, input int per, input logic [2:0] rate);
		logic [31:0] v;
		v = rnd();
		wr(`IDX_PORT_SEL, 32'(port), 2'h0);
		wr(`IDX_BC_RATE, {29'h0, rate}, 2'h0);
		rd(`IDX_BC_RATE, {31'h0, rate});
		bc_port = port;
		bc_per = per;
		exp_bc.push_back({1'b1, v[7:0]});
		wr(`IDX_BC_TX, v, 2'h0);
		while (exp_bc.size() != 0) @(posedge aclk);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------
	// result watchers
	// ----------------
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			eb2 = exp_b.pop_front();
			`CHK("bresp", eb2, bresp)
		end
		if (rvalid && rready) begin
			er = exp_r.pop_front();
			`CHK("read", er, {rresp, rdata})
		end
		if (tx_valid && tx_ready) begin
			et = exp_tx.pop_front();
			`CHK("tx word", et, tx_word)
		end
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	// back line decoder: samples mid-bit, lsb first, stop bit on top
	initial forever begin
		@(posedge aclk);
		if (aresetn && bc_per > 0 && !back_line[bc_port]) begin
			repeat (bc_per / 2) @(posedge aclk);
			for (int k = 0; k < 9; k++) begin
				repeat (bc_per) @(posedge aclk);
				bc_got[k] = back_line[bc_port];
			end
			ebc = exp_bc.pop_front();
			`CHK("back byte", ebc, bc_got)
		end
	end

	// ----------------
	// scenarios
	// ----------------
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		mode_strap = 1'b0;
		slow = 1'b1;
		seed = 32'd71411;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		do_reset(1'b0);
		rd(`IDX_FWD_CTL, 34'h3F);
		rd(`IDX_VC_MAP, 34'hE4);
		rd(`IDX_BC_RATE, 34'h0);
		rd(`IDX_RX_PORT_SETUP, 34'h0);
		rd(8'h21, {2'h2, 32'h0});
		wr(8'h21, 32'h1, 2'h2);
		$display("end reset values");
		for (int p = 0; p < 4; p++) begin
			r = rnd();
			fmt[p] = r[1:0];
			wr(`IDX_PORT_SEL, 32'(p), 2'h0);
			wr(`IDX_RX_PORT_SETUP, {30'h0, fmt[p]}, 2'h0);
		end
		for (int p = 0; p < 4; p++) begin
			wr(`IDX_PORT_SEL, 32'(p), 2'h0);
			rd(`IDX_RX_PORT_SETUP, {32'h0, fmt[p]});
			wr(`IDX_RX_PORT_SETUP, 32'h0, 2'h0);
		end
		r = rnd();
		wr(`IDX_FWD_CTL, {26'h0, r[1:0], 4'h2}, 2'h0);
		@(posedge aclk);
		`CHK("lanes", r[1:0], lanes)
		$display("end port setup");
		wr(`IDX_PORT_SEL, 32'h1, 2'h0);
		wr(`IDX_VC_MAP, 32'h1B, 2'h0);
		r = rnd();
		it = {r[31:16], r[9:8], r[5:0]};
		mit = {r[31:16], ~r[9:8], r[5:0]};
		exp_tx.push_back({1'b1, ecc(mit), mit});
		hub_partner_inst.send(1, csi_unit(r[15:8], 1'b1, it), 40);
		r = rnd();
		exp_tx.push_back({1'b0, 8'h00, r[23:0]});
		hub_partner_inst.send(1, csi_unit(r[31:24], 1'b0, r[23:0]), 40);
		while (exp_tx.size() != 0) @(posedge aclk);
		rd(`IDX_RX_STATUS, {24'h0, 2'h3, r[31:24]});
		rd(`IDX_RX_STATUS, {24'h0, 2'h2, r[31:24]});
		wr(`IDX_FWD_CTL, 32'h30, 2'h0);
		hub_partner_inst.send(1, csi_unit(8'h5A, 1'b0, 24'h0), 40);
		repeat (20) @(posedge aclk);
		$display("end csi2 stream");
		slow <= 1'b0;
		bc(0, 1, 3'h0);
		bc(3, 5, `BC_RATE_NONSYNC);
		bc(2, 1, 3'h5);
		$display("end back channel");
		do_reset(1'b1);
		rd(`IDX_RX_PORT_SETUP, 34'h1);
		wr(`IDX_PORT_SEL, 32'h2, 2'h0);
		wr(`IDX_FWD_CTL, 32'h34, 2'h0);
		wr(`IDX_VC_MAP, 32'hE6, 2'h0);
		r = rnd();
		exp_tx.push_back({1'b1, ecc(24'h80), 24'h80});
		exp_tx.push_back({1'b0, 20'h0, r[11:0]});
		exp_tx.push_back({1'b1, ecc(24'h81), 24'h81});
		hub_partner_inst.send(2, raw_unit(2'b10, 12'h0), 28);
		hub_partner_inst.send(2, raw_unit(2'b11, r[11:0]), 28);
		hub_partner_inst.send(2, raw_unit(2'b00, 12'h0), 28);
		while (exp_tx.size() != 0) @(posedge aclk);
		bc(2, 20, 3'h0);
		$display("end raw stream");
		end_sim();
	end
endmodule // sensor_hub_test

bind sensor_hub hub_checker hub_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .back_line(back_line), .tx_word(tx_word),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_lanes_m1(tx_lanes_m1));
